// [verilog/exec_regs_regs.svh]
// Register offsets, field positions, reset values and timing counts of the execute block
`ifndef EXEC_REGS_REGS_SVH
`define EXEC_REGS_REGS_SVH

`define OFS_INSTR        12'h000
`define OFS_ACC          12'h004
`define OFS_STATUS       12'h008
`define OFS_PC           12'h00c
`define OFS_WDT          12'h010
`define OFS_STACK        12'h014
`define OFS_CTRL         12'h018
`define OFS_MEM_BASE     12'h100
`define OFS_MEM_LAST     12'h1fc

`define INSTR_OP_LSB     0
`define INSTR_ADDR_LSB   8
`define INSTR_IMM_LSB    16

`define ST_CARRY         0
`define ST_HALF_CARRY    1
`define ST_ZERO          2
`define ST_OVERFLOW      3
`define ST_POWER_DOWN    4
`define ST_WDT_TIMEOUT   5
`define ST_GIE           6
`define ST_PRE1_SEEN     7
`define ST_PRE2_SEEN     8
`define ST_BUSY          9
`define ST_HALTED        10

`define CTRL_WAKE        0
`define CTRL_WDT_ENABLE  1

`define RST_BYTE         8'h00
`define RST_PC           10'h000
`define WDT_CLEARED      8'h00
`define WDT_LAST         8'hff
`define BCD_LIMIT        4'h9
`define BCD_CORRECTION   4'h6
`define PRESCALE_DEFAULT 16'h0100

`endif

// [verilog/exec_pkg.sv]
// Types shared by the instruction execute block
package exec_pkg;

    typedef enum logic [4:0] {
        OP_IDLE, OP_PRECLEAR1, OP_PRECLEAR2, OP_INVERT_MEM, OP_INVERT_ACC,
        OP_BCD_ADJUST, OP_SUB_ONE, OP_SUB_ONE_ACC, OP_ADD_ONE, OP_ADD_ONE_ACC,
        OP_BRANCH, OP_COPY_MEM_ACC, OP_COPY_IMM, OP_COPY_ACC_MEM, OP_OR_MEM,
        OP_OR_IMM, OP_OR_INTO_RAM, OP_POP_PC, OP_POP_CONST, OP_INT_EXIT,
        OP_ROTATE_LEFT, OP_ROTATE_LEFT_ACC, OP_POWER_DOWN
    } op_t;

    typedef enum {
        ST_IDLE, ST_EXEC, ST_POP2, ST_HALT
    } state_t;

    typedef struct packed {
        op_t        op;
        logic [5:0] addr;
        logic [9:0] imm;
    } instr_t;

    typedef struct packed {
        logic carry;
        logic half_carry;
        logic zero;
        logic overflow;
    } flags_t;

endpackage

// [verilog/mcu_instruction_execute.sv]
// Instruction execute datapath with data memory, stack, watchdog and APB slave
// What this block does
// - Both preclears run: clear watchdog and flags
// - One preclear alone: only record it
// - Invert memory byte, update zero only
// - Invert byte into accumulator, memory kept
// - Low nibble adjust, sets nibble adjust carry if half carry was clear
// - High nibble adjust with carry, carry only
// - Decrement in place or into accumulator
// - Power down: pc+1, stop, watchdog cleared
// - Increment in place or into accumulator
// - Branch loads pc, flags unchanged
// - Immediate constant into accumulator, no flags
// - Move byte memory/accumulator, no flags
// - Idle only advances pc
// - OR forms, update zero only
// - Pop pc from stack, two cycles
// - Pop pc and load constant
// - Interrupt exit pops pc, enables interrupts
// - Rotate memory byte left in place
// - Rotate left into accumulator, memory kept
`timescale 1ns/1ps
`default_nettype none
`include "exec_regs_regs.svh"

module mcu_instruction_execute
    import exec_pkg::*;
#(
    parameter logic [15:0] PRESCALE_DIV = `PRESCALE_DEFAULT
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_halted,
    output logic             o_global_interrupt_enable
);

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0]  mem [0:63];
    logic [9:0]  stack [0:3];
    logic [1:0]  sp;
    logic [7:0]  acc;
    logic [9:0]  pc;
    flags_t      flags;
    logic        power_down_flag;
    logic        watchdog_timeout_flag;
    logic        pre1_seen;
    logic        pre2_seen;
    logic        wdt_enable;
    logic [7:0]  wdt_count;
    logic [15:0] prescale;
    state_t      state;
    instr_t      cur;

    logic        access;
    logic        wr;
    logic        mem_hit;
    logic [5:0]  mem_idx;
    logic        mapped;
    logic        instr_take;
    logic        wake_req;
    logic        wdt_tick;
    logic        wdt_overflow;
    logic        exec;
    logic        wdt_clear;

    // Datapath results
    logic [7:0]  opnd;
    logic [7:0]  result;
    logic        to_mem;
    logic        to_acc;
    logic        zero_upd;
    logic        carry_upd;
    logic        carry_val;
    logic [3:0]  low_adj;
    logic        nibble_adjust_carry;
    logic [4:0]  high_sum;
    logic [3:0]  high_adj;
    logic [1:0]  sp_prev;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign access     = i_psel && i_penable && o_pready;
    assign wr         = access && i_pwrite;
    assign mem_hit    = (i_paddr >= `OFS_MEM_BASE) && (i_paddr <= `OFS_MEM_LAST)
                        && (i_paddr[1:0] == 2'b00);
    assign mem_idx    = i_paddr[7:2];
    assign mapped     = mem_hit || (i_paddr == `OFS_INSTR) || (i_paddr == `OFS_ACC)
                        || (i_paddr == `OFS_STATUS) || (i_paddr == `OFS_PC)
                        || (i_paddr == `OFS_WDT) || (i_paddr == `OFS_STACK)
                        || (i_paddr == `OFS_CTRL);
    // New instructions are only accepted while the core is idle
    assign instr_take = wr && (i_paddr == `OFS_INSTR) && (state == ST_IDLE);
    assign wake_req   = wr && (i_paddr == `OFS_CTRL) && i_pwdata[`CTRL_WAKE];
    assign exec       = (state == ST_EXEC);
    assign sp_prev    = sp - 2'd1;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= i_psel && i_penable && !o_pready;
            o_pslverr <= i_psel && i_penable && !o_pready && !mapped;
            o_prdata  <= 32'h0000_0000;
            if (i_psel && i_penable && !o_pready && !i_pwrite) begin
                if (mem_hit) begin
                    o_prdata <= {24'h000000, mem[mem_idx]};
                end else begin
                    case (i_paddr)
                        `OFS_INSTR:  o_prdata <= {6'h00, cur.imm, 2'h0, cur.addr,
                                                  3'h0, cur.op};
                        `OFS_ACC:    o_prdata <= {24'h000000, acc};
                        `OFS_STATUS: o_prdata <= {21'h000000, o_halted,
                                                  state != ST_IDLE, pre2_seen,
                                                  pre1_seen, o_global_interrupt_enable,
                                                  watchdog_timeout_flag, power_down_flag,
                                                  flags.overflow, flags.zero,
                                                  flags.half_carry, flags.carry};
                        `OFS_PC:     o_prdata <= {22'h000000, pc};
                        `OFS_WDT:    o_prdata <= {24'h000000, wdt_count};
                        `OFS_STACK:  o_prdata <= {20'h00000, sp, stack[sp_prev]};
                        `OFS_CTRL:   o_prdata <= {30'h00000000, wdt_enable, 1'b0};
                        default:     o_prdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (instr_take) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    case (cur.op)
                        OP_POP_PC, OP_POP_CONST, OP_INT_EXIT: state <= ST_POP2;
                        OP_POWER_DOWN:                        state <= ST_HALT;
                        default:                              state <= ST_IDLE;
                    endcase
                end
                ST_POP2: state <= ST_IDLE;
                ST_HALT: begin
                    // Clock stopped: only a wake write or a watchdog overflow restarts
                    if (wake_req || wdt_overflow) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cur      <= '{op: OP_IDLE, addr: 6'h00, imm: 10'h000};
            o_halted <= 1'b0;
        end else begin
            if (instr_take) begin
                cur.op   <= op_t'(i_pwdata[`INSTR_OP_LSB +: 5]);
                cur.addr <= i_pwdata[`INSTR_ADDR_LSB +: 6];
                cur.imm  <= i_pwdata[`INSTR_IMM_LSB +: 10];
            end
            if (exec && cur.op == OP_POWER_DOWN) begin
                o_halted <= 1'b1;
            end else if (state == ST_HALT && (wake_req || wdt_overflow)) begin
                o_halted <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath
    always_comb begin
        opnd                = mem[cur.addr];
        result              = opnd;
        to_mem              = 1'b0;
        to_acc              = 1'b0;
        zero_upd            = 1'b0;
        carry_upd           = 1'b0;
        carry_val           = flags.carry;
        low_adj             = acc[3:0];
        nibble_adjust_carry = 1'b0;
        high_sum            = 5'h00;
        high_adj            = 4'h0;
        case (cur.op)
            OP_INVERT_MEM: begin
                result   = ~opnd;
                to_mem   = 1'b1;
                zero_upd = 1'b1;
            end
            OP_INVERT_ACC: begin
                result   = ~opnd;
                to_acc   = 1'b1;
                zero_upd = 1'b1;
            end
            OP_BCD_ADJUST: begin
                if (acc[3:0] > `BCD_LIMIT || flags.half_carry) begin
                    low_adj             = acc[3:0] + `BCD_CORRECTION;
                    nibble_adjust_carry = !flags.half_carry;
                end
                high_sum = {1'b0, acc[7:4]} + {4'h0, nibble_adjust_carry};
                if (high_sum > {1'b0, `BCD_LIMIT} || flags.carry) begin
                    high_adj  = high_sum[3:0] + `BCD_CORRECTION;
                    carry_upd = 1'b1;
                    carry_val = 1'b1;
                end else begin
                    high_adj = high_sum[3:0];
                end
                result = {high_adj, low_adj};
                to_mem = 1'b1;
            end
            OP_SUB_ONE, OP_SUB_ONE_ACC: begin
                result   = opnd - 8'h01;
                to_mem   = (cur.op == OP_SUB_ONE);
                to_acc   = (cur.op == OP_SUB_ONE_ACC);
                zero_upd = 1'b1;
            end
            OP_ADD_ONE, OP_ADD_ONE_ACC: begin
                result   = opnd + 8'h01;
                to_mem   = (cur.op == OP_ADD_ONE);
                to_acc   = (cur.op == OP_ADD_ONE_ACC);
                zero_upd = 1'b1;
            end
            OP_COPY_MEM_ACC: begin
                result = opnd;
                to_acc = 1'b1;
            end
            OP_COPY_ACC_MEM: begin
                result = acc;
                to_mem = 1'b1;
            end
            OP_COPY_IMM, OP_POP_CONST: begin
                result = cur.imm[7:0];
                to_acc = 1'b1;
            end
            OP_OR_MEM, OP_OR_INTO_RAM: begin
                result   = acc | opnd;
                to_acc   = (cur.op == OP_OR_MEM);
                to_mem   = (cur.op == OP_OR_INTO_RAM);
                zero_upd = 1'b1;
            end
            OP_OR_IMM: begin
                result   = acc | cur.imm[7:0];
                to_acc   = 1'b1;
                zero_upd = 1'b1;
            end
            OP_ROTATE_LEFT, OP_ROTATE_LEFT_ACC: begin
                result = {opnd[6:0], opnd[7]};
                to_mem = (cur.op == OP_ROTATE_LEFT);
                to_acc = (cur.op == OP_ROTATE_LEFT_ACC);
            end
            default: begin
                result = opnd;
            end
        endcase
    end

    // Software may load memory only while no instruction is in flight
    always_ff @(posedge i_core_clk) begin
        if (exec && to_mem) begin
            mem[cur.addr] <= result;
        end else if (wr && mem_hit && state == ST_IDLE) begin
            mem[mem_idx] <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            acc <= `RST_BYTE;
        end else if (exec && to_acc) begin
            acc <= result;
        end else if (wr && i_paddr == `OFS_ACC && state == ST_IDLE) begin
            acc <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            flags                     <= '0;
            o_global_interrupt_enable <= 1'b0;
        end else if (exec) begin
            if (zero_upd) begin
                flags.zero <= (result == 8'h00);
            end
            if (carry_upd) begin
                flags.carry <= carry_val;
            end
            if (cur.op == OP_INT_EXIT) begin
                o_global_interrupt_enable <= 1'b1;
            end
        end else if (wr && i_paddr == `OFS_STATUS && state == ST_IDLE) begin
            flags.carry               <= i_pwdata[`ST_CARRY];
            flags.half_carry          <= i_pwdata[`ST_HALF_CARRY];
            flags.zero                <= i_pwdata[`ST_ZERO];
            flags.overflow            <= i_pwdata[`ST_OVERFLOW];
            o_global_interrupt_enable <= i_pwdata[`ST_GIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and return stack
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pc <= `RST_PC;
            sp <= 2'd0;
        end else if (exec) begin
            case (cur.op)
                OP_BRANCH: pc <= cur.imm;
                OP_POP_PC, OP_POP_CONST, OP_INT_EXIT: begin
                    pc <= stack[sp_prev];
                    sp <= sp_prev;
                end
                default: pc <= pc + 10'h001;
            endcase
        end else if (wr && i_paddr == `OFS_PC && state == ST_IDLE) begin
            pc <= i_pwdata[9:0];
        end else if (wr && i_paddr == `OFS_STACK && state == ST_IDLE) begin
            sp <= sp + 2'd1;
        end
    end

    // Four-deep circular stack: a fifth push overwrites the oldest entry
    always_ff @(posedge i_core_clk) begin
        if (wr && i_paddr == `OFS_STACK && state == ST_IDLE) begin
            stack[sp] <= i_pwdata[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog and preclear pairing
    assign wdt_tick     = wdt_enable && (prescale == PRESCALE_DIV - 16'h0001);
    assign wdt_overflow = wdt_tick && (wdt_count == `WDT_LAST);
    assign wdt_clear    = exec && ((cur.op == OP_PRECLEAR1 && pre2_seen)
                          || (cur.op == OP_PRECLEAR2 && pre1_seen)
                          || cur.op == OP_POWER_DOWN);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wdt_enable <= 1'b0;
        end else if (wr && i_paddr == `OFS_CTRL) begin
            wdt_enable <= i_pwdata[`CTRL_WDT_ENABLE];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prescale  <= 16'h0000;
            wdt_count <= `WDT_CLEARED;
        end else if (wdt_clear) begin
            prescale  <= 16'h0000;
            wdt_count <= `WDT_CLEARED;
        end else if (wdt_enable) begin
            prescale <= wdt_tick ? 16'h0000 : prescale + 16'h0001;
            if (wdt_tick) begin
                wdt_count <= wdt_count + 8'h01;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pre1_seen <= 1'b0;
            pre2_seen <= 1'b0;
        end else if (wdt_clear) begin
            pre1_seen <= 1'b0;
            pre2_seen <= 1'b0;
        end else if (exec && cur.op == OP_PRECLEAR1) begin
            pre1_seen <= 1'b1;
        end else if (exec && cur.op == OP_PRECLEAR2) begin
            pre2_seen <= 1'b1;
        end
    end

    // A timeout in the same cycle as a clear still sets the flag
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            power_down_flag       <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (exec && cur.op == OP_POWER_DOWN) begin
                power_down_flag <= 1'b1;
            end else if (wdt_clear) begin
                power_down_flag <= 1'b0;
            end
            if (wdt_overflow) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (wdt_clear) begin
                watchdog_timeout_flag <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [dv/mcu_instruction_execute_chk.sv]
// Port-level assertions for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_execute_chk
    import exec_pkg::*;
#(
    parameter logic [15:0] PRESCALE_DIV = 16'h0100
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_halted,
    input wire logic        o_global_interrupt_enable
);
    logic wr_op;
    logic bad_addr;
    assign wr_op = i_psel && i_penable && o_pready && i_pwrite && (i_paddr == 12'h000);
    // Misaligned addresses, the gap between the last register and the memory window, and above it
    assign bad_addr = (i_paddr[1:0] != 2'b00) || i_paddr > 12'h1fc
                      || (i_paddr > 12'h018 && i_paddr < 12'h100);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready held past one cycle");
    ready_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready not one cycle after access");
    ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access phase");
    err_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    err_unmapped_a: assert property (o_pready && bad_addr |-> o_pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (o_pready && !bad_addr |-> !o_pslverr)
        else $error("mapped access refused");
    err_zero_data_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read returned data");
    halt_enter_a: assert property (wr_op && i_pwdata[4:0] == 5'h16 |-> ##[1:3] o_halted)
        else $error("power down did not halt");
    exit_enable_a: assert property (wr_op && i_pwdata[4:0] == 5'h13
        |-> ##[1:4] o_global_interrupt_enable)
        else $error("interrupt exit left enable low");
endmodule
bind mcu_instruction_execute mcu_instruction_execute_chk #(.PRESCALE_DIV(PRESCALE_DIV)) i_chk (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_halted(o_halted),
    .o_global_interrupt_enable(o_global_interrupt_enable));
`default_nettype wire

// [dv/tb_mcu_instruction_execute.sv]
// Self-checking bench for the instruction execute block
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_instruction_execute;
    import exec_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
    logic        i_core_clk = 1'h0;
    logic        i_rst = 1'h1;
    logic        i_psel = 1'h0;
    logic        i_penable = 1'h0;
    logic        i_pwrite = 1'h0;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_halted;
    logic        o_global_interrupt_enable;
    note_t       notes[$];
    note_t       n;
    int          n_errors = 0;
    int          n_tests = 0;
    int          seed = 32'h81d3;
    logic [31:0] q;
    logic [7:0]  w0;
    mcu_instruction_execute #(.PRESCALE_DIV(16'h0004)) i_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_halted(o_halted),
        .o_global_interrupt_enable(o_global_interrupt_enable));
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Oldest note is compared at the edge where the access completes
    always @(posedge i_core_clk) begin
        if (i_psel && i_penable && o_pready === 1'h1) begin
            n = notes.pop_front();
            n_tests++;
            if ((o_prdata & n.m) !== (n.d & n.m) || o_pslverr !== n.e) begin
                n_errors++;
                $display("MISMATCH %0t: addr %h data %h err %b", $time, i_paddr, o_prdata, o_pslverr);
            end
        end
    end
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int k;
        notes.push_back('{d, m, e});
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'h1;
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_pready !== 1'h1 && k < 20);
        q = o_prdata;
        if (o_pready !== 1'h1) begin
            n_errors++;
            $display("MISMATCH %0t: no ready", $time);
            test_done();
        end
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge i_core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'h0);
        bus(1'h1, a, d, 32'h0, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        bus(1'h0, a, d, m,
            a > 12'h1fc || (a > 12'h018 && a < 12'h100) || a[1:0] != 2'h0);
    endtask
    // Busy is polled because pops take one cycle more; a halted core stays busy
    task automatic run(input logic [4:0] op, input logic [5:0] a, input logic [9:0] x);
        int k;
        wr(12'h000, {6'h0, x, 2'h0, a, 3'h0, op});
        k = 0;
        do begin
            rd(12'h008, 32'h0, 32'h0);
            k++;
        end while (q[9] !== 1'h0 && q[10] !== 1'h1 && k < 20);
        if (q[9] !== 1'h0 && q[10] !== 1'h1) begin
            n_errors++;
            $display("MISMATCH %0t: core stayed busy", $time);
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    function automatic void model(input int op, input logic [7:0] a, m, x,
                                  input logic [3:0] f, output logic [7:0] na, nm,
                                  output logic [3:0] nf);
        logic [4:0] hi;
        logic [3:0] lo;
        logic       c1;
        na = a;
        nm = m;
        nf = f;
        lo = a[3:0];
        c1 = 1'h0;
        case (op)
            3: nm = ~m;
            4: na = ~m;
            5: begin
                if (a[3:0] > 4'h9 || f[1]) begin
                    lo = a[3:0] + 4'h6;
                    c1 = ~f[1];
                end
                hi = {1'h0, a[7:4]} + {4'h0, c1};
                if (hi > 5'h09 || f[0]) begin
                    hi = hi + 5'h06;
                    nf[0] = 1'h1;
                end
                nm = {hi[3:0], lo};
            end
            6: nm = m - 8'h1;
            7: na = m - 8'h1;
            8: nm = m + 8'h1;
            9: na = m + 8'h1;
            11: na = m;
            12, 18: na = x;
            13: nm = a;
            14: na = a | m;
            15: na = a | x;
            16: nm = a | m;
            20: nm = {m[6:0], m[7]};
            21: na = {m[6:0], m[7]};
            default: ;
        endcase
        if (op inside {3, 6, 8, 16}) nf[2] = (nm == 8'h0);
        if (op inside {4, 7, 9, 14, 15}) nf[2] = (na == 8'h0);
    endfunction
    task automatic op_case(input int op);
        logic [7:0]  a, m, na, nm;
        logic [3:0]  f, nf;
        logic [9:0]  pc, stk, x, npc;
        logic [11:0] ma;
        a = $random(seed);
        m = $random(seed);
        f = $random(seed);
        pc = $random(seed);
        stk = $random(seed);
        x = $random(seed);
        ma = {4'h1, 6'($random(seed)), 2'h0};
        model(op, a, m, x[7:0], f, na, nm, nf);
        npc = (op == 10) ? x : (op >= 17 && op <= 19) ? stk : pc + 10'h1;
        wr(ma, {24'h0, m});
        wr(12'h004, {24'h0, a});
        wr(12'h008, {28'h0, f});
        wr(12'h00c, {22'h0, pc});
        wr(12'h014, {22'h0, stk});
        run(op[4:0], ma[7:2], x);
        rd(12'h004, {24'h0, na}, 32'hffffffff);
        rd(ma, {24'h0, nm}, 32'hffffffff);
        rd(12'h008, {25'h0, op == 19, 2'h0, nf}, 32'h0000004f);
        rd(12'h00c, {22'h0, npc}, 32'h000003ff);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'h0;
        @(posedge i_core_clk);
        rd(12'h004, 32'h0, 32'hffffffff);
        rd(12'h008, 32'h0, 32'h000007ff);
        rd(12'h020, 32'h0, 32'hffffffff);
        wr(12'h200, $random(seed), 1'h1);
        $display("Reset and map test done");
        for (int op = 0; op < 22; op++) begin
            if (op != 1 && op != 2) repeat (4) op_case(op);
        end
        $display("Instruction test done");
        // Age the watchdog past a wrap so the timeout flag is set
        wr(12'h018, 32'h2);
        repeat (1100) @(posedge i_core_clk);
        wr(12'h018, 32'h0);
        rd(12'h008, 32'h00000020, 32'h00000020);
        wr(12'h00c, 32'h000003ff);
        run(5'h16, 6'h0, 10'h0);
        rd(12'h008, 32'h00000610, 32'h00000630);
        rd(12'h010, 32'h0, 32'h000000ff);
        rd(12'h00c, 32'h0, 32'h000003ff);
        wr(12'h018, 32'h1);
        rd(12'h008, 32'h00000010, 32'h00000430);
        wr(12'h018, 32'h2);
        repeat (1100) @(posedge i_core_clk);
        wr(12'h018, 32'h0);
        rd(12'h010, 32'h0, 32'h0);
        w0 = q[7:0];
        run(5'h01, 6'h0, 10'h0);
        rd(12'h010, {24'h0, w0}, 32'h000000ff);
        rd(12'h008, 32'h000000b0, 32'h000001b0);
        run(5'h02, 6'h0, 10'h0);
        rd(12'h010, 32'h0, 32'h000000ff);
        rd(12'h008, 32'h0, 32'h000001b0);
        $display("Watchdog and power down test done");
        test_done();
    end
endmodule
`default_nettype wire
